// file: sdrs_pkg.sv
// Purpose: constants for the stepper driver register set
// Assumes: APB, 32-bit data, one word per register index
// Notes:   byte address of each register is four times its index
//
// What this block does
// RULE1: chopper_config at 0x6C is read/write, resets to 0x10410150.
// RULE2: voltage_pwm_config at 0x70 is write-only, resets to 0xC40C001E.
// RULE3: commutation mode entered by enable pin or minimum-velocity threshold; control at 0x6E.
// RULE4: low control field limits PWM on time to field times one clock.
// RULE5: software sets on-time limit slightly above effective blank time.
// RULE6: bits 23:16 limit on time for stall detect, times 16 clocks; zero disables.
// RULE7: software sets stall field slightly above one sixteenth of on-time limit.
// RULE8: stall limit also applies above high velocity when fullstep option set.
// RULE9: read-only status at 0x6F returns load value and error flags.
// RULE10: 0x71 bits 7:0 report actual duty cycle scaling both table currents.
// RULE11: 0x71 bits 24:16 report signed 9-bit regulator offset, -255 to +255.
// RULE12: 0x72 reports auto offset in 7:0 and auto gradient in 23:16.
// RULE13: in commutation mode, steps taken while ready is low are counted at 0x73.
// RULE14: skipped-step counter follows direction and wraps modulo 2^20.
// RULE15: unused control and readback bits read zero and ignore writes.
// RULE16: skipped-step counter and regulator results clear to zero on reset.
`default_nettype none

package sdrs_pkg;
  // register indices; byte address is index shifted left by two
  localparam logic [7:0]  IDX_CHOPPER   = 8'h6C;
  localparam logic [7:0]  IDX_SMART_CUR = 8'h6D;
  localparam logic [7:0]  IDX_COMM_CTRL = 8'h6E;
  localparam logic [7:0]  IDX_STATUS    = 8'h6F;
  localparam logic [7:0]  IDX_VPWM      = 8'h70;
  localparam logic [7:0]  IDX_REG_RES   = 8'h71;
  localparam logic [7:0]  IDX_AUTO_PWM  = 8'h72;
  localparam logic [7:0]  IDX_SKIPPED   = 8'h73;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h74;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h75;
  localparam logic [7:0]  IDX_OPTIONS   = 8'h76;

  localparam logic [31:0] CHOPPER_RST   = 32'h10410150;
  localparam logic [31:0] VPWM_RST      = 32'hC40C001E;
  localparam logic [24:0] SMART_MASK    = 25'h1FFFFFF;

  // commutation control field layout
  localparam int ONTIME_LSB = 0;
  localparam int ONTIME_W   = 10;
  localparam int STALL_LSB  = 16;
  localparam int STALL_W    = 8;
  // readback field positions
  localparam int DUTY_LSB   = 0;
  localparam int OFFS_LSB   = 16;
  localparam int AOFS_LSB   = 0;
  localparam int AGRAD_LSB  = 16;

  // timing: on-time unit is one clock, stall unit is sixteen clocks
  localparam int CLK_PERIOD_NS  = 8;
  localparam int ONTIME_UNIT_CYC = 1;
  localparam int STALL_UNIT_CYC  = 16;
  localparam int STALL_SHIFT     = 4;  // log2 of STALL_UNIT_CYC

  // interrupt status bits
  localparam int IRQ_SKIP   = 0;
  localparam int IRQ_ONTIME = 1;
  localparam int IRQ_STALL  = 2;
  localparam int IRQ_W      = 3;

  // option bits
  localparam int OPT_HIGH_VELOCITY_THRESHOLD_FS  = 0;
  localparam int OPT_HIGH_VELOCITY_THRESHOLD_CHM = 1;

  localparam int SKIP_W = 20;
endpackage

`default_nettype wire

// file: sdrs_skip_counter.sv
// Purpose: counts step inputs lost while commutation is not ready
// Assumes: step and dir synchronous to pclk
// Notes:   counter wraps, never saturates
`default_nettype none

module sdrs_skip_counter
  import sdrs_pkg::*;
#(
  parameter int W = SKIP_W
) (
  input  wire logic         pclk,      // clock
  input  wire logic         presetn,   // async reset, low active
  input  wire logic         ce,        // clock enable
  input  wire logic         step_in,   // step input level
  input  wire logic         dir_in,    // 1 counts up
  input  wire logic         comm_mode, // commutation mode active
  input  wire logic         ready_in,  // commutation ready output
  output logic [W-1:0]      count,     // skipped step count
  output logic              skip_pulse // one cycle per skipped step
);
  logic step_d_reg;
  logic skip_now;

  // rising edge of step while the motor cannot follow
  assign skip_now = step_in & ~step_d_reg & comm_mode & ~ready_in; // RULE13

  // edge detector history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_d_reg <= 1'b0;
    end else if (ce) begin
      step_d_reg <= step_in;
    end
  end

  // natural wrap of W-bit arithmetic gives modulo 2^W
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count      <= '0; // RULE16
      skip_pulse <= 1'b0;
    end else if (ce) begin
      skip_pulse <= skip_now;
      if (skip_now) begin
        count <= dir_in ? count + W'(1) : count - W'(1); // RULE14
      end
    end
  end

  skip_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && skip_now |=> count == ($past(dir_in) ? $past(count) + W'(1) : $past(count) - W'(1))) // RULE14
    else $error("skipped step not counted by direction");
  skip_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(comm_mode && !ready_in) |=> $stable(count)) // RULE13
    else $error("counter moved outside skip condition");
  skip_reset_a: assert property (@(posedge pclk) !presetn |-> count == '0) // RULE16
    else $error("counter not cleared in reset");
  skip_wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
    skip_now && dir_in && count == {W{1'b1}});
endmodule

`default_nettype wire

// file: sdrs_regs.sv
// Purpose: driver register set with commutation on-time and stall timing
// Assumes: all inputs synchronous to pclk; APB zero-wait slave
// Notes:   readback inputs are sampled every enabled cycle
`default_nettype none

module sdrs_regs
  import sdrs_pkg::*;
(
  input  wire logic         pclk,           // clock, 125 MHz
  input  wire logic         presetn,        // async reset, low active
  input  wire logic         ce,             // clock enable
  input  wire logic         psel,           // apb select
  input  wire logic         penable,        // apb access phase
  input  wire logic         pwrite,         // apb write
  input  wire logic [11:0]  paddr,          // apb byte address
  input  wire logic [31:0]  pwdata,         // apb write data
  output logic [31:0]       prdata,         // apb read data
  output logic              pready,         // apb ready
  output logic              pslverr,        // apb error, unmapped
  input  wire logic         commutation_enable_pin, // mode enable pin
  input  wire logic         min_velocity_reached,   // commutation_min_velocity crossed
  input  wire logic         above_high_velocity,    // high_velocity_threshold crossed
  input  wire logic         pwm_on,         // phase pwm on level
  input  wire logic         step_in,        // step input
  input  wire logic         dir_in,         // direction input
  input  wire logic         commutation_ready_output, // ready level
  input  wire logic [31:0]  status_in,      // load value and error flags
  input  wire logic [7:0]   actual_duty_cycle,  // duty, 255 full voltage
  input  wire logic [8:0]   regulator_offset,   // signed offset
  input  wire logic [7:0]   auto_offset_value,  // auto offset
  input  wire logic [7:0]   auto_gradient_value, // auto gradient
  output logic [31:0]       chopper_config,       // chopper word
  output logic [24:0]       smart_current_config, // smart current word
  output logic [31:0]       voltage_pwm_config,   // voltage pwm word
  output logic              commutation_mode,     // mode active
  output logic              on_time_limit,        // force pwm off
  output logic              stall_detect,         // step loss seen
  output logic              high_vel_chopper_mode, // option out
  output logic [15:0]       phase_a_scaled,       // scaled table a
  output logic [15:0]       phase_b_scaled,       // scaled table b
  input  wire logic [7:0]   phase_a_table_current, // table a
  input  wire logic [7:0]   phase_b_table_current, // table b
  output logic              irq            // level interrupt
);

  // register storage
  logic [ONTIME_W-1:0] ontime_limit_reg;
  logic [STALL_W-1:0]  stall_on_reg;
  logic [31:0]         status_reg;
  logic [24:0]         reg_result_reg;
  logic [23:0]         auto_pwm_reg;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic [1:0]          options_reg;
  logic [17:0]         on_cnt_reg;
  logic [SKIP_W-1:0]   skip_count;
  logic                skip_pulse;
  logic                ontime_hit;
  logic                stall_hit;
  logic                stall_armed;
  logic                bus_setup;
  logic                bus_wr;
  logic                bus_rd;
  logic                addr_ok;
  logic [31:0]         rd_next;
  logic [IRQ_W-1:0]    irq_events;
  logic                ontime_d_reg;

  // byte address match for a register index, used for every decode
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  assign bus_setup = ce & psel & ~penable;
  assign bus_wr    = ce & psel & penable & pready & pwrite;
  assign bus_rd    = ce & psel & penable & pready & ~pwrite;

  // address decode and read mux; write-only words read zero
  always_comb begin
    addr_ok = 1'b1;
    rd_next = 32'h00000000;
    if (hit(paddr, IDX_CHOPPER)) begin
      rd_next = chopper_config; // RULE1
    end else if (hit(paddr, IDX_SMART_CUR)) begin
      rd_next = 32'h00000000;
    end else if (hit(paddr, IDX_COMM_CTRL)) begin
      rd_next = 32'h00000000; // RULE15
    end else if (hit(paddr, IDX_STATUS)) begin
      rd_next = status_reg; // RULE9
    end else if (hit(paddr, IDX_VPWM)) begin
      rd_next = 32'h00000000; // RULE2
    end else if (hit(paddr, IDX_REG_RES)) begin
      rd_next = {7'h00, reg_result_reg}; // RULE10 RULE11 RULE15
    end else if (hit(paddr, IDX_AUTO_PWM)) begin
      rd_next = {8'h00, auto_pwm_reg}; // RULE12 RULE15
    end else if (hit(paddr, IDX_SKIPPED)) begin
      rd_next = {12'h000, skip_count}; // RULE13
    end else if (hit(paddr, IDX_IRQ_STAT)) begin
      rd_next = {29'h0, irq_stat_reg};
    end else if (hit(paddr, IDX_IRQ_MASK)) begin
      rd_next = {29'h0, irq_mask_reg};
    end else if (hit(paddr, IDX_OPTIONS)) begin
      rd_next = {30'h0, options_reg};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // apb answer: ready in the cycle after setup, data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= bus_setup;
      if (bus_setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_next;
        pslverr <= ~addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // writable configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chopper_config       <= CHOPPER_RST; // RULE1
      voltage_pwm_config   <= VPWM_RST;    // RULE2
      smart_current_config <= '0;
      ontime_limit_reg     <= '0;
      stall_on_reg         <= '0;
      options_reg          <= '0;
      irq_mask_reg         <= '0;
    end else if (bus_wr) begin
      if (hit(paddr, IDX_CHOPPER)) begin
        chopper_config <= pwdata; // RULE1
      end else if (hit(paddr, IDX_SMART_CUR)) begin
        smart_current_config <= pwdata[24:0] & SMART_MASK;
      end else if (hit(paddr, IDX_COMM_CTRL)) begin
        // bits between the two fields are dropped
        ontime_limit_reg <= pwdata[ONTIME_LSB +: ONTIME_W]; // RULE4 RULE15
        stall_on_reg     <= pwdata[STALL_LSB +: STALL_W];   // RULE6
      end else if (hit(paddr, IDX_VPWM)) begin
        voltage_pwm_config <= pwdata; // RULE2
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end else if (hit(paddr, IDX_OPTIONS)) begin
        options_reg <= pwdata[1:0];
      end
    end
  end

  // readback capture; zero until first sample after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg     <= '0;
      reg_result_reg <= '0; // RULE16
      auto_pwm_reg   <= '0; // RULE16
    end else if (ce) begin
      status_reg <= status_in; // RULE9
      reg_result_reg <= {regulator_offset, 8'h00, actual_duty_cycle}; // RULE10 RULE11
      auto_pwm_reg   <= {auto_gradient_value, 8'h00, auto_offset_value}; // RULE12
    end
  end

  // duty cycle scales both table currents, kept as full product
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_a_scaled <= '0;
      phase_b_scaled <= '0;
    end else if (ce) begin
      phase_a_scaled <= phase_a_table_current * actual_duty_cycle; // RULE10
      phase_b_scaled <= phase_b_table_current * actual_duty_cycle; // RULE10
    end
  end

  // mode entry: pin or velocity threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_mode      <= 1'b0;
      high_vel_chopper_mode <= 1'b0;
    end else if (ce) begin
      commutation_mode      <= commutation_enable_pin | min_velocity_reached; // RULE3
      high_vel_chopper_mode <= options_reg[OPT_HIGH_VELOCITY_THRESHOLD_CHM];
    end
  end

  // on-time measured in clocks; 18 bits covers 255 times 16
  assign stall_armed = (commutation_mode |
                        (above_high_velocity & options_reg[OPT_HIGH_VELOCITY_THRESHOLD_FS])) & // RULE8
                       (stall_on_reg != '0); // RULE6
  assign ontime_hit  = commutation_mode & pwm_on &
                       (on_cnt_reg >= 18'(ontime_limit_reg) * 18'(ONTIME_UNIT_CYC)); // RULE4
  assign stall_hit   = stall_armed & pwm_on &
                       (on_cnt_reg == 18'(stall_on_reg) * 18'(STALL_UNIT_CYC)); // RULE6

  // on-time counter restarts each time pwm turns off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_reg <= '0;
    end else if (ce) begin
      if (!pwm_on) begin
        on_cnt_reg <= '0;
      end else if (on_cnt_reg != '1) begin
        on_cnt_reg <= on_cnt_reg + 18'h00001;
      end
    end
  end

  // limit and stall outputs, one cycle after the count reaches the on-time field or sixteen times the stall field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_time_limit <= 1'b0;
      stall_detect  <= 1'b0;
    end else if (ce) begin
      on_time_limit <= ontime_hit; // RULE4
      stall_detect  <= stall_hit;  // RULE6 RULE8
    end
  end

  sdrs_skip_counter #(
    .W          (SKIP_W)
  ) u_skip (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .step_in    (step_in),
    .dir_in     (dir_in),
    .comm_mode  (commutation_mode),
    .ready_in   (commutation_ready_output),
    .count      (skip_count),
    .skip_pulse (skip_pulse)
  );

  // event vector in status bit order; a long on-time pulse counts once
  always_comb begin
    irq_events             = '0;
    irq_events[IRQ_SKIP]   = skip_pulse;                    // RULE13
    irq_events[IRQ_ONTIME] = on_time_limit & ~ontime_d_reg; // RULE4
    irq_events[IRQ_STALL]  = stall_detect;                  // RULE6
  end

  // sticky status, read clears, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else if (ce) begin
      if (bus_rd && hit(paddr, IDX_IRQ_STAT)) begin
        // clear only what the read returned; bits set after setup stay
        irq_stat_reg <= (irq_stat_reg & ~prdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // on-time limit history for the rising-edge event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ontime_d_reg <= 1'b0;
    end else if (ce) begin
      ontime_d_reg <= on_time_limit;
    end
  end

  // checks
  chop_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    bus_wr && hit(paddr, IDX_CHOPPER) |=> chopper_config == $past(pwdata))
    else $error("chopper word not written");
  vpwm_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    bus_setup && !pwrite && hit(paddr, IDX_VPWM) |=> prdata == 32'h00000000)
    else $error("write-only word read back nonzero");
  mode_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    ce && (commutation_enable_pin || min_velocity_reached) |=> commutation_mode)
    else $error("commutation mode not entered");
  ontime_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ce && commutation_mode && pwm_on && on_cnt_reg >= 18'(ontime_limit_reg) |=> on_time_limit)
    else $error("on-time limit missed");
  stall_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    stall_detect |-> $past(stall_on_reg) != '0)
    else $error("stall seen with detection disabled");
  stall_high_velocity_threshold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    ce && !commutation_mode && above_high_velocity && !options_reg[OPT_HIGH_VELOCITY_THRESHOLD_FS] |=> !stall_detect)
    else $error("stall outside permitted modes");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    ce && bus_setup && !pwrite && hit(paddr, IDX_STATUS) |=> prdata == $past(status_reg))
    else $error("status readback wrong");
  reg_result_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    ce |=> reg_result_reg[24:16] == $past(regulator_offset) && reg_result_reg[15:8] == 8'h00)
    else $error("regulator offset field wrong");
  auto_pwm_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ce |=> auto_pwm_reg[23:16] == $past(auto_gradient_value))
    else $error("auto gradient field wrong");
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    bus_setup && !pwrite && hit(paddr, IDX_COMM_CTRL) |=> prdata == 32'h00000000)
    else $error("control word not read as zero");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(irq_stat_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised");
  stat_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |irq_events |=> (irq_stat_reg & $past(irq_events)) == $past(irq_events))
    else $error("status event lost");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_setup |=> pready)
    else $error("no ready after setup");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_setup && !addr_ok |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");
  phase_scale_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    ce |=> phase_b_scaled == 16'($past(phase_b_table_current)) * 16'($past(actual_duty_cycle)))
    else $error("phase current not scaled by duty");
  chm_option_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    ce |=> high_vel_chopper_mode == $past(options_reg[OPT_HIGH_VELOCITY_THRESHOLD_CHM]))
    else $error("chopper mode option not passed on");

  stall_seen_c: cover property (@(posedge pclk) disable iff (!presetn) stall_detect);
  limit_seen_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(on_time_limit));
  skip_irq_c:   cover property (@(posedge pclk) disable iff (!presetn) skip_pulse ##[1:4] irq);
endmodule

`default_nettype wire

// file: sdrs_step_src.sv
// Purpose: step and direction source facing the driver register set
// Assumes: one pclk domain, steps issued in bursts on request
// Notes:   each step is two cycles high then two low, so steps never merge
`default_nettype none

module sdrs_step_src (
  input  wire logic       pclk,     // clock
  input  wire logic       presetn,  // async reset, low active
  input  wire logic       start,    // begin a burst
  input  wire logic [7:0] n_steps,  // steps in burst
  input  wire logic       dir,      // burst direction
  output logic            step_out, // step level
  output logic            dir_out,  // direction level
  output logic            busy      // burst running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [1:0] ph;

  // burst sequencer; direction only changes between bursts, never mid-step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left     <= 8'h00;
      ph       <= 2'h0;
      step_out <= 1'b0;
      dir_out  <= 1'b0;
      busy     <= 1'b0;
    end else if (!busy) begin
      step_out <= 1'b0;
      if (start && n_steps != 8'h00) begin
        left    <= n_steps;
        dir_out <= dir;
        busy    <= 1'b1;
        ph      <= 2'h0;
      end
    end else begin
      ph       <= ph + 2'h1;
      step_out <= ~ph[1];
      if (ph == 2'h3) begin
        left <= left - 8'h01;
        busy <= (left != 8'h01);
      end
    end
  end
endmodule

`default_nettype wire

// file: sdrs_tb.sv
// Purpose: self-checking bench for the stepper driver register set
// Assumes: zero-wait apb slave, step source model on the step pins
// Notes:   reads queue their expected word; a monitor compares on completion
`default_nettype none

module testbench import sdrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, ce, psel, penable, pwrite, pwm_on, start, sdir, busy, step_in, dir_in;
  logic        commutation_enable_pin, min_velocity_reached, above_high_velocity, commutation_ready_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, status_in, prdata, chopper_config, voltage_pwm_config, d;
  logic [7:0]  actual_duty_cycle, auto_offset_value, auto_gradient_value, nst;
  logic [7:0]  phase_a_table_current, phase_b_table_current;
  logic [8:0]  regulator_offset;
  logic [24:0] smart_current_config;
  logic [15:0] phase_a_scaled, phase_b_scaled, p16;
  logic        pready, pslverr, commutation_mode, on_time_limit, stall_detect, high_vel_chopper_mode, irq;
  logic [32:0] q[$];
  int          err_total, n_tests, k1, k2;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  sdrs_regs sdrs_regs_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .commutation_enable_pin, .min_velocity_reached, .above_high_velocity, .pwm_on, .step_in, .dir_in,
    .commutation_ready_output, .status_in, .actual_duty_cycle, .regulator_offset, .auto_offset_value,
    .auto_gradient_value, .chopper_config, .smart_current_config, .voltage_pwm_config, .commutation_mode,
    .on_time_limit, .stall_detect, .high_vel_chopper_mode, .phase_a_scaled, .phase_b_scaled,
    .phase_a_table_current, .phase_b_table_current, .irq);

  sdrs_step_src sdrs_step_src_i (.pclk, .presetn, .start, .n_steps(nst), .dir(sdir), .step_out(step_in),
    .dir_out(dir_in), .busy);

  task report_and_stop;
    if (q.size() != 0) err_total++; // reads never completed
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (!pready && i < 20);
    if (!pready) begin err_total++; report_and_stop(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask

  task rd(input logic [7:0] idx, input logic [32:0] e);
    q.push_back(e);
    xfer(1'b0, idx, 32'h0);
  endtask

  // burst of steps from the source model, bounded wait for its end
  task steps(input logic dr, input logic [7:0] n);
    int i;
    @(posedge pclk);
    sdir <= dr; nst <= n; start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    i = 0;
    do begin @(posedge pclk); i++; end while (busy && i < 2000);
    if (busy) begin err_total++; report_and_stop(); end
    repeat (3) @(posedge pclk);
  endtask

  // cycles of pwm on time until the chosen flag shows; 100 means never
  task meas(input logic sel, output int k);
    k = 0;
    @(posedge pclk);
    pwm_on <= 1'b1;
    do begin @(posedge pclk); k++; end while (!(sel ? stall_detect : on_time_limit) && k < 100);
    pwm_on <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // read monitor: pairs each completed read with the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (q.size() != 0) chk({pslverr, prdata}, q.pop_front());
      else begin
        err_total++;
        $display("ERROR t=%0t unexpected read %h", $time, prdata);
      end
    end
  end

  initial begin
    void'($urandom(32809));
    {presetn, psel, penable, pwrite, pwm_on, start, sdir, commutation_enable_pin} = 8'h00;
    {min_velocity_reached, above_high_velocity, commutation_ready_output} = 3'h0;
    ce = 1'b1; paddr = 12'h000; pwdata = 32'h0; status_in = 32'h0; nst = 8'h00; regulator_offset = 9'h000;
    {actual_duty_cycle, auto_offset_value, auto_gradient_value} = 24'h0;
    {phase_a_table_current, phase_b_table_current} = 16'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk({1'b0, chopper_config}, {1'b0, CHOPPER_RST});
    chk({1'b0, voltage_pwm_config}, {1'b0, VPWM_RST});
    rd(IDX_CHOPPER, {1'b0, CHOPPER_RST});
    rd(IDX_SKIPPED, 33'h0);
    rd(IDX_REG_RES, 33'h0);
    rd(8'h00, 33'h1_0000_0000);
    d = $urandom;
    wr(IDX_CHOPPER, d);
    rd(IDX_CHOPPER, {1'b0, d});
    d = $urandom;
    wr(IDX_VPWM, d);
    rd(IDX_VPWM, 33'h0);
    chk({1'b0, voltage_pwm_config}, {1'b0, d});
    wr(IDX_SMART_CUR, d);
    rd(IDX_SMART_CUR, 33'h0);
    chk({8'h0, smart_current_config}, {8'h0, d[24:0]});
    wr(IDX_COMM_CTRL, 32'hFFFFFFFF);
    rd(IDX_COMM_CTRL, 33'h0);
    // readback words follow their live sources
    status_in <= $urandom; actual_duty_cycle <= $urandom; regulator_offset <= $urandom;
    auto_offset_value <= $urandom; auto_gradient_value <= $urandom; phase_a_table_current <= $urandom;
    phase_b_table_current <= $urandom;
    repeat (4) @(posedge pclk);
    p16 = phase_a_table_current * actual_duty_cycle;
    chk({17'h0, phase_a_scaled}, {17'h0, p16});
    p16 = phase_b_table_current * actual_duty_cycle;
    chk({17'h0, phase_b_scaled}, {17'h0, p16});
    rd(IDX_STATUS, {1'b0, status_in});
    rd(IDX_REG_RES, {8'h0, regulator_offset, 8'h0, actual_duty_cycle});
    rd(IDX_AUTO_PWM, {9'h0, auto_gradient_value, 8'h0, auto_offset_value});
    // skipped steps only while in mode and not ready
    commutation_enable_pin <= 1'b1;
    steps(1'b1, 8'd5);
    chk({32'h0, commutation_mode}, 33'h1);
    rd(IDX_SKIPPED, 33'h5);
    commutation_ready_output <= 1'b1;
    steps(1'b1, 8'd3);
    rd(IDX_SKIPPED, 33'h5);
    commutation_ready_output <= 1'b0;
    steps(1'b0, 8'd7);
    rd(IDX_SKIPPED, 33'hFFFFE);
    chk({32'h0, irq}, 33'h0);
    rd(IDX_IRQ_STAT, 33'h1);
    commutation_enable_pin <= 1'b0; min_velocity_reached <= 1'b1;
    steps(1'b1, 8'd1);
    rd(IDX_SKIPPED, 33'hFFFFF);
    wr(IDX_IRQ_MASK, 32'h1);
    steps(1'b0, 8'd1);
    chk({32'h0, irq}, 33'h1);
    rd(IDX_IRQ_STAT, 33'h1);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    ce <= 1'b0;
    steps(1'b1, 8'd1);
    ce <= 1'b1;
    rd(IDX_SKIPPED, 33'hFFFFE);
    min_velocity_reached <= 1'b0;
    steps(1'b1, 8'd2);
    rd(IDX_SKIPPED, 33'hFFFFE);
    // on-time limit and stall window measured as differences
    commutation_enable_pin <= 1'b1;
    wr(IDX_COMM_CTRL, 32'h0000_0004);
    meas(1'b0, k1);
    wr(IDX_COMM_CTRL, 32'h0000_000C);
    meas(1'b0, k2);
    chk(33'(k2 - k1), 33'd8);
    wr(IDX_COMM_CTRL, 32'h0002_0010);
    meas(1'b1, k1);
    wr(IDX_COMM_CTRL, 32'h0003_0010);
    meas(1'b1, k2);
    chk(33'(k2 - k1), 33'd16);
    wr(IDX_COMM_CTRL, 32'h0000_0010);
    meas(1'b1, k2);
    chk(33'(k2), 33'd100);
    // stall window above high velocity with fullstep option, mode off
    wr(IDX_COMM_CTRL, 32'h0002_0010);
    wr(IDX_OPTIONS, 32'h3);
    commutation_enable_pin <= 1'b0; above_high_velocity <= 1'b1;
    meas(1'b1, k2);
    chk(33'(k2), 33'(k1));
    chk({32'h0, high_vel_chopper_mode}, 33'h1);
    wr(IDX_OPTIONS, 32'h0);
    meas(1'b1, k2);
    chk(33'(k2), 33'd100);
    chk({32'h0, high_vel_chopper_mode}, 33'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire
